// *** logic/evcu_top.sv ***
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
// Operation
// RULE1 - Soft or hard reset pin: reset at 00100.
// RULE2 - Data bus error, machine check or parity: 00200.
// RULE3 - Data fault at 00300; cause bit when untranslated.
// RULE4 - Cause bit when protection refuses access.
// RULE5 - Cause bit: external word write-through, direct-store.
// RULE6 - Direction bit set for store, clear for load.
// RULE7 - Cause bit: external word with access enable clear.
// RULE8 - Untranslatable fetch: fault at 00400.
// RULE9 - Keys and page protection deny read: fetch fault.
// RULE10 - Enabled interrupt with pin high: 00500.
// RULE11 - Floating load/store not word aligned: 00600.
// RULE12 - Unaligned multiple, reserve, conditional: align.
// RULE13 - Little-endian unaligned single access: align.
// RULE14 - Little-endian multiple or string: align.
// RULE15 - Cache zero, write-through or inhibited: align.
// RULE16 - Maskable interrupt waits for completion or idle.
// RULE17 - Exception saves both save registers, vectors.
// RULE18 - Vector offset zero never selected.
// RULE19 - One at a time; reset, machine check first.
module evcu_top
  import evcu_pkg::*;
(
  input wire logic aclk, // Core clock
  input wire logic aresetn, // Synchronous reset, active low

  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready

  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready

  input wire logic soft_reset_input, // Soft reset pin, high active
  input wire logic hard_reset_input, // Hard reset pin, high active
  input wire logic transfer_error_ack, // Bus transfer error pin
  input wire logic machine_check_input, // Machine check pin
  input wire logic ext_irq_input, // External interrupt pin
  input wire logic data_bus_active, // Data bus transaction in progress
  input wire logic parity_error, // Address or data parity error

  input wire logic [31:0] cur_pc, // Address of next instruction
  input wire logic [31:0] cur_msr, // Processor state to save

  input wire logic instr_busy, // Instructions in execution units
  input wire logic instr_complete, // Instruction completes this cycle

  input wire logic mem_access, // Data access checked this cycle
  input wire logic mem_is_store, // Access is a store
  input wire logic xlate_miss, // No page group or block translation
  input wire logic protect_fault, // Page or block protection refused
  input wire logic ext_word_op, // External control word instruction
  input wire logic target_write_thru, // Target marked write-through
  input wire logic direct_store_seg, // Load/store hits direct-store segment

  input wire logic fetch_req, // Instruction fetch this cycle
  input wire logic fetch_xlate_miss, // Fetch address untranslatable
  input wire logic supervisor_key, // Segment supervisor key
  input wire logic user_key, // Segment user key
  input wire logic [1:0] page_protect_bits, // Page protection bits
  input wire logic in_supervisor, // Fetch made in supervisor state

  input wire logic fp_ldst, // Floating-point load or store
  input wire logic multi_or_resv, // Multiple, reserve or conditional word
  input wire logic single_ldst, // Single-register load or store
  input wire logic string_op, // String instruction
  input wire logic cache_zero_op, // Cache block zero instruction
  input wire logic cache_inhibited, // Target caching inhibited
  input wire logic [1:0] ea_low, // Low operand address bits
  input wire logic [1:0] operand_size, // 0 byte, 1 half, 2 word, 3 double

  output logic exc_take, // Exception taken, high for the one cycle after each selection
  output logic [19:0] vector_offset, // Offset of the taken vector
  output logic [31:0] save_restore_addr_reg, // Saved return address
  output logic [31:0] save_restore_state_reg, // Saved processor state
  output logic irq // Level interrupt to system
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] hr_sync;
    logic [1:0] sr_sync;
    logic [1:0] tea_sync;
    logic [1:0] mc_sync;
    logic [1:0] int_sync;
    logic [1:0] par_sync;

    logic ext_pend;
    logic take;

    logic [19:0] vec;
    logic [31:0] srr_addr;
    logic [31:0] srr_state;

    logic [4:0] cause;
    logic [2:0] ctrl;
    logic [NUM_EXC-1:0] status;
    logic [NUM_EXC-1:0] enable;

    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } evcu_state_s;

  evcu_state_s st;
  evcu_state_s next_st;

  // Alignment check: operand must sit on a boundary of its own size, at most a word boundary for a double
  function automatic logic misaligned(input logic [1:0] a,
                                      input logic [1:0] sz);
    unique case (sz)
      2'd0: misaligned = 1'b0;
      2'd1: misaligned = a[0];
      default: misaligned = |a;
    endcase
  endfunction

  // Read permission from keys and protection bits
  function automatic logic read_denied(input logic key,
                                       input logic [1:0] pp);
    read_denied = key & (pp == 2'b00);
  endfunction

  // ----------------------------------------------------------------
  // Condition decode
  // ----------------------------------------------------------------
  logic le_mode;
  logic cond_reset;
  logic cond_mchk;
  logic cond_dfault;
  logic cond_ffault;
  logic cond_align;
  logic cond_ext;

  logic active_key;
  evcu_exc_e sel;

  // Raw conditions per exception; pins read after two stages, the interrupt pin after three (ext_pend), data_bus_active directly
  always_comb begin
    le_mode = st.ctrl[CTRL_LITTLE_END];
    active_key = in_supervisor ? supervisor_key : user_key;
    cond_reset = st.hr_sync[1] | st.sr_sync[1]; // [RULE1]

    cond_mchk = (st.tea_sync[1] & data_bus_active) | st.mc_sync[1]
                | st.par_sync[1]; // [RULE2]

    cond_dfault = mem_access & (xlate_miss | protect_fault
                  | (ext_word_op & target_write_thru)
                  | (~ext_word_op & direct_store_seg)
                  | (ext_word_op & ~st.ctrl[CTRL_EXT_ACC_EN])); // [RULE3]

    cond_ffault = fetch_req & (fetch_xlate_miss // [RULE8]
                  | read_denied(active_key, page_protect_bits)); // [RULE9]

    cond_align = (fp_ldst & misaligned(ea_low, 2'd2)) // [RULE11]
                 | (multi_or_resv & (|ea_low)) // [RULE12]
                 | (le_mode & single_ldst
                    & misaligned(ea_low, operand_size)) // [RULE13]
                 | (le_mode & (multi_or_resv | string_op)) // [RULE14]
                 | (cache_zero_op
                    & (target_write_thru | cache_inhibited)); // [RULE15]

    // Maskable interrupt only at an instruction boundary or when idle
    cond_ext = st.ext_pend & st.ctrl[CTRL_EXT_IRQ_EN]
               & (instr_complete | ~instr_busy); // [RULE10] [RULE16]
  end

  // Fixed priority, a single winner per cycle
  always_comb begin
    if (cond_reset) begin // [RULE19]
      sel = EXC_RESET;
    end else if (cond_mchk) begin
      sel = EXC_MCHK;
    end else if (cond_dfault) begin
      sel = EXC_DFAULT;
    end else if (cond_ffault) begin
      sel = EXC_FFAULT;
    end else if (cond_align) begin
      sel = EXC_ALIGN;
    end else if (cond_ext) begin
      sel = EXC_EXTIRQ;
    end else begin
      sel = EXC_NONE;
    end
  end

  // ----------------------------------------------------------------
  // Bus decode helpers
  // ----------------------------------------------------------------
  logic wr_fire;
  logic rd_fire;
  logic [31:0] rd_val;
  logic rd_ok;

  logic [NUM_EXC-1:0] clr_mask;
  logic [NUM_EXC-1:0] evt;

  // Read mux and write strobe timing
  always_comb begin
    wr_fire = st.aw_held & st.w_held & ~st.bvalid;
    rd_fire = s_axi_arvalid & ~st.rvalid;

    rd_ok = 1'b1;
    rd_val = 32'h0000_0000;

    unique case (s_axi_araddr)
      ADDR_CTRL: rd_val = {29'h0, st.ctrl};
      ADDR_CAUSE: rd_val = {27'h0, st.cause};
      ADDR_VECTOR: rd_val = {12'h000, st.vec};
      ADDR_SAVE_ADDR: rd_val = st.srr_addr;
      ADDR_SAVE_STATE: rd_val = st.srr_state;
      ADDR_IRQ_STATUS: rd_val = {26'h0, st.status};
      ADDR_IRQ_ENABLE: rd_val = {26'h0, st.enable};
      ADDR_IRQ_CLEAR: rd_val = 32'h0000_0000;
      default: rd_ok = 1'b0;
    endcase

    clr_mask = '0;
    if (wr_fire && st.aw_addr == ADDR_IRQ_CLEAR && st.w_strb[0]) begin
      clr_mask = st.w_data[NUM_EXC-1:0];
    end

    evt = '0;
    if (sel != EXC_NONE) begin
      evt[3'(sel) - 3'd1] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.hr_sync = {st.hr_sync[0], hard_reset_input};
    next_st.sr_sync = {st.sr_sync[0], soft_reset_input};
    next_st.tea_sync = {st.tea_sync[0], transfer_error_ack};
    next_st.mc_sync = {st.mc_sync[0], machine_check_input};
    next_st.int_sync = {st.int_sync[0], ext_irq_input};
    next_st.par_sync = {st.par_sync[0], parity_error};

    // Interrupt request follows the level of its pin
    next_st.ext_pend = st.int_sync[1];

    next_st.take = sel != EXC_NONE;
    if (sel != EXC_NONE) begin
      next_st.vec = evcu_vector(sel); // [RULE17] [RULE18]
      next_st.srr_addr = cur_pc; // [RULE17]
      next_st.srr_state = cur_msr;
    end

    if (sel == EXC_DFAULT) begin
      next_st.cause[CAUSE_NO_XLATE] = xlate_miss; // [RULE3]
      next_st.cause[CAUSE_PROTECT] = protect_fault; // [RULE4]
      next_st.cause[CAUSE_DIRECT_STORE] =
        (ext_word_op & target_write_thru)
        | (~ext_word_op & direct_store_seg); // [RULE5]
      next_st.cause[CAUSE_STORE] = mem_is_store; // [RULE6]
      next_st.cause[CAUSE_EXT_ACC_OFF] =
        ext_word_op & ~st.ctrl[CTRL_EXT_ACC_EN]; // [RULE7]
    end

    // Sticky status: a new event wins over a clear in the same cycle
    next_st.status = (st.status & ~clr_mask) | evt;

    // Write address and data accepted in either order
    if (s_axi_awvalid && !st.aw_held) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end

    if (s_axi_wvalid && !st.w_held) begin
      next_st.w_held = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end

    if (wr_fire) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_OKAY;
      unique case (st.aw_addr)
        ADDR_CTRL: begin
          if (st.w_strb[0]) begin
            next_st.ctrl = st.w_data[2:0];
          end
        end
        ADDR_IRQ_ENABLE: begin
          if (st.w_strb[0]) begin
            next_st.enable = st.w_data[NUM_EXC-1:0];
          end
        end
        ADDR_CAUSE, ADDR_VECTOR, ADDR_SAVE_ADDR, ADDR_SAVE_STATE,
        ADDR_IRQ_STATUS, ADDR_IRQ_CLEAR: begin
          next_st.bresp = RESP_OKAY;
        end
        default: next_st.bresp = RESP_SLVERR;
      endcase
    end

    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end

    if (rd_fire) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = rd_val;
      next_st.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.ctrl <= CTRL_RESET;
      st.bresp <= RESP_OKAY;
      st.rresp <= RESP_OKAY;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = ~st.aw_held;
  assign s_axi_wready = ~st.w_held;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;

  assign s_axi_arready = ~st.rvalid;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;

  assign exc_take = st.take;
  assign vector_offset = st.vec;
  assign save_restore_addr_reg = st.srr_addr;
  assign save_restore_state_reg = st.srr_state;
  // Interrupt high while any enabled sticky bit is set
  assign irq = |(st.status & st.enable);

endmodule

// *** pkg/evcu_pkg.sv ***
package evcu_pkg;

  // ----------------------------------------------------------------
  // Vector offsets
  // ----------------------------------------------------------------
  localparam logic [19:0] VEC_RESERVED = 20'h0_0000;
  localparam logic [19:0] VEC_SYS_RESET = 20'h0_0100;
  localparam logic [19:0] VEC_MACH_CHECK = 20'h0_0200;
  localparam logic [19:0] VEC_DATA_FAULT = 20'h0_0300;
  localparam logic [19:0] VEC_FETCH_FAULT = 20'h0_0400;
  localparam logic [19:0] VEC_EXT_IRQ = 20'h0_0500;
  localparam logic [19:0] VEC_ALIGN = 20'h0_0600;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CAUSE = 8'h04;
  localparam logic [7:0] ADDR_VECTOR = 8'h08;
  localparam logic [7:0] ADDR_SAVE_ADDR = 8'h0C;
  localparam logic [7:0] ADDR_SAVE_STATE = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h18;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h1C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_EXT_IRQ_EN = 0;
  localparam int CTRL_EXT_ACC_EN = 1;
  localparam int CTRL_LITTLE_END = 2;
  localparam int CAUSE_NO_XLATE = 0;
  localparam int CAUSE_PROTECT = 1;
  localparam int CAUSE_DIRECT_STORE = 2;
  localparam int CAUSE_STORE = 3;
  localparam int CAUSE_EXT_ACC_OFF = 4;
  localparam int NUM_EXC = 6;

  // ----------------------------------------------------------------
  // Reset values and AXI responses
  // ----------------------------------------------------------------
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    EXC_NONE = 3'b000,
    EXC_RESET = 3'b001,
    EXC_MCHK = 3'b010,
    EXC_DFAULT = 3'b011,
    EXC_FFAULT = 3'b100,
    EXC_EXTIRQ = 3'b101,
    EXC_ALIGN = 3'b110
  } evcu_exc_e;

  // Vector offset for a selected exception; none maps to the reserved one
  function automatic logic [19:0] evcu_vector(input evcu_exc_e e);
    unique case (e)
      EXC_RESET: evcu_vector = VEC_SYS_RESET;
      EXC_MCHK: evcu_vector = VEC_MACH_CHECK;
      EXC_DFAULT: evcu_vector = VEC_DATA_FAULT;
      EXC_FFAULT: evcu_vector = VEC_FETCH_FAULT;
      EXC_EXTIRQ: evcu_vector = VEC_EXT_IRQ;
      EXC_ALIGN: evcu_vector = VEC_ALIGN;
      default: evcu_vector = VEC_RESERVED;
    endcase
  endfunction

endpackage

// *** tb/evcu_checker_assertions.sv ***
`timescale 1ns/10ps
module evcu_checker
  import evcu_pkg::*;
(
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, active low
  input wire logic soft_reset_input, // Soft reset pin
  input wire logic hard_reset_input, // Hard reset pin
  input wire logic transfer_error_ack, // Bus error pin
  input wire logic machine_check_input, // Machine check pin
  input wire logic parity_error, // Parity error pin
  input wire logic ext_irq_input, // External interrupt pin
  input wire logic instr_busy, // Instructions executing
  input wire logic instr_complete, // Instruction completes
  input wire logic mem_access, // Data access
  input wire logic xlate_miss, // No translation
  input wire logic fetch_req, // Fetch
  input wire logic fetch_xlate_miss, // Fetch untranslatable
  input wire logic fp_ldst, // Floating-point load or store
  input wire logic [1:0] ea_low, // Low address bits
  input wire logic [31:0] cur_pc, // Return address
  input wire logic [31:0] cur_msr, // Processor state
  input wire logic exc_take, // Exception taken
  input wire logic [19:0] vector_offset, // Vector offset
  input wire logic [31:0] save_restore_addr_reg, // Saved address
  input wire logic [31:0] save_restore_state_reg // Saved state
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  logic [1:0] quiet;
  logic pins;
  assign pins = soft_reset_input | hard_reset_input | transfer_error_ack |
    machine_check_input | parity_error;
  // Cycles with all high-priority pins low
  always_ff @(posedge aclk) begin
    if (!aresetn || pins) quiet <= 2'h0;
    else if (quiet != 2'h3) quiet <= quiet + 2'h1;
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_zero_unused: assert property (
    exc_take |-> vector_offset != VEC_RESERVED)
    else $error("vector offset zero selected");
  a_data_vector: assert property (
    quiet == 2'h3 && mem_access && xlate_miss |=>
    exc_take && vector_offset == VEC_DATA_FAULT)
    else $error("data fault not vectored");
  a_fetch_vector: assert property (
    quiet == 2'h3 && !mem_access && fetch_req && fetch_xlate_miss
    |=> exc_take && vector_offset == VEC_FETCH_FAULT)
    else $error("fetch fault not vectored");
  a_align_vector: assert property (
    quiet == 2'h3 && !mem_access && !fetch_req && fp_ldst &&
    ea_low != 2'h0 |=> exc_take && vector_offset == VEC_ALIGN)
    else $error("alignment not vectored");
  a_hard_reset: assert property (
    hard_reset_input [*5] |-> exc_take && vector_offset == VEC_SYS_RESET)
    else $error("hard reset not taken");
  a_mcheck_pin: assert property (
    (machine_check_input && !hard_reset_input && !soft_reset_input) [*5]
    |-> exc_take && vector_offset == VEC_MACH_CHECK)
    else $error("machine check not taken");
  a_ext_needs_pin: assert property (
    (!ext_irq_input) [*6] |-> !(exc_take && vector_offset == VEC_EXT_IRQ))
    else $error("interrupt taken without pin");
  a_ext_deferred: assert property (
    (instr_busy && !instr_complete) [*2] |->
    !(exc_take && vector_offset == VEC_EXT_IRQ))
    else $error("interrupt taken while busy");
  a_state_saved: assert property (
    exc_take |-> save_restore_addr_reg == $past(cur_pc) &&
    save_restore_state_reg == $past(cur_msr))
    else $error("state not saved");
  a_outputs_hold: assert property (
    !exc_take |-> $stable(vector_offset) && $stable(save_restore_addr_reg))
    else $error("outputs changed without exception");
endmodule
bind evcu_top evcu_checker u_chk (.aclk, .aresetn, .soft_reset_input,
  .hard_reset_input, .transfer_error_ack, .machine_check_input,
  .parity_error, .ext_irq_input, .instr_busy, .instr_complete, .mem_access,
  .xlate_miss, .fetch_req, .fetch_xlate_miss, .fp_ldst, .ea_low, .cur_pc,
  .cur_msr, .exc_take, .vector_offset, .save_restore_addr_reg,
  .save_restore_state_reg);

// *** tb/evcu_sys_model.sv ***
`timescale 1ns/10ps
module evcu_sys_model (
  input wire logic aclk, // Core clock
  output logic soft_reset_input, // Soft reset pin
  output logic hard_reset_input, // Hard reset pin
  output logic transfer_error_ack, // Bus error pin
  output logic machine_check_input, // Machine check pin
  output logic ext_irq_input, // External interrupt pin
  output logic parity_error, // Parity error pin
  output logic data_bus_active // Data bus transaction
);
  logic [6:0] pins = 7'h00;
  // Pins follow the last pattern
  assign {data_bus_active, parity_error, ext_irq_input, machine_check_input,
    transfer_error_ack, hard_reset_input, soft_reset_input} = pins;
  // Drives pins after an edge
  task automatic drive(input logic [6:0] m);
    @(posedge aclk);
    pins <= m;
  endtask
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/10ps
module testbench
  import evcu_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, cur_pc, cur_msr, rdv;
  logic [31:0] save_restore_addr_reg, save_restore_state_reg;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, exc_take, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, ea_low, operand_size, rsp;
  logic [1:0] page_protect_bits;
  logic soft_reset_input, hard_reset_input, transfer_error_ack;
  logic machine_check_input, ext_irq_input, parity_error;
  logic data_bus_active, instr_busy, instr_complete;
  logic [19:0] vector_offset;
  logic [17:0] cond;
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  evcu_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .soft_reset_input, .hard_reset_input,
    .transfer_error_ack, .machine_check_input, .ext_irq_input,
    .data_bus_active, .parity_error, .cur_pc, .cur_msr, .instr_busy,
    .instr_complete, .mem_access(cond[0]), .mem_is_store(cond[1]),
    .xlate_miss(cond[2]), .protect_fault(cond[3]), .ext_word_op(cond[4]),
    .target_write_thru(cond[5]), .direct_store_seg(cond[6]),
    .fetch_req(cond[7]), .fetch_xlate_miss(cond[8]),
    .supervisor_key(cond[9]), .user_key(cond[10]), .page_protect_bits,
    .in_supervisor(cond[11]), .fp_ldst(cond[12]), .multi_or_resv(cond[13]),
    .single_ldst(cond[14]), .string_op(cond[15]), .cache_zero_op(cond[16]),
    .cache_inhibited(cond[17]), .ea_low, .operand_size, .exc_take,
    .vector_offset, .save_restore_addr_reg, .save_restore_state_reg, .irq);
  evcu_sys_model sys (.aclk, .soft_reset_input, .hard_reset_input,
    .transfer_error_ack, .machine_check_input, .ext_irq_input,
    .parity_error, .data_bus_active);
  // ----------------------------------------------------------------
  // Clock, timeout and checking
  // ----------------------------------------------------------------
  always #12.5 aclk = ~aclk;
  // Cuts a hung run short
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      miscompares++;
      final_report;
    end
  end
  task automatic final_report;
    $display("checks %0d, miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] v, e);
    n_checks++;
    if (v !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", nm, e, v);
    end
  endtask
  // Handshakes are sampled and acted on at the rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rdv = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rc(input string nm, input logic [7:0] a, logic [31:0] e);
    rd(a);
    chk(nm, rdv, e);
  endtask
  // Conditions for one edge
  task automatic fire(input logic [17:0] c);
    @(posedge aclk);
    cond <= c;
    cur_pc <= {14'h0, c};
    cur_msr <= {c, 14'h0};
    @(posedge aclk);
    cond <= 18'h0_0000;
  endtask
  task automatic exc(input logic [19:0] v);
    int i = 0;
    do begin
      @(negedge aclk);
      i++;
    end while (exc_take !== 1'b1 && i < 12);
    chk("take", {31'h0, exc_take}, 32'h1);
    chk("vector", {12'h000, vector_offset}, {12'h000, v});
    chk("saved addr", save_restore_addr_reg, cur_pc);
    chk("saved state", save_restore_state_reg, cur_msr);
    @(posedge aclk);
  endtask
  task automatic none(input int n);
    int s = 0;
    repeat (n) begin
      @(negedge aclk);
      if (exc_take !== 1'b0) s++;
    end
    chk("no take", s, 32'h0);
    @(posedge aclk);
  endtask
  task automatic al(input logic [17:0] c, input logic [1:0] e,
    input logic [31:0] m, input logic t);
    wr(ADDR_CTRL, m);
    ea_low <= e;
    fire(c);
    if (t) exc(VEC_ALIGN);
    else none(6);
  endtask
  task automatic pin(input logic [6:0] m, input int n, logic [19:0] v);
    sys.drive(m);
    repeat (n) @(posedge aclk);
    if (v == VEC_RESERVED) none(8);
    else exc(v);
    sys.drive(7'h00);
    repeat (8) @(posedge aclk);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, cur_pc, cur_msr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, instr_busy, instr_complete, ea_low} = '0;
    {page_protect_bits, cond} = '0;
    s_axi_wstrb = 4'hf;
    operand_size = 2'h2;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rc("ctrl", ADDR_CTRL, 32'h0);
    rd(8'h40);
    chk("unmapped resp", rsp, RESP_SLVERR);
    wr(ADDR_IRQ_ENABLE, 32'h4);
    fire(18'h0_0007); // Store with no translation
    exc(VEC_DATA_FAULT);
    rc("cause", ADDR_CAUSE, 32'h9);
    rc("status", ADDR_IRQ_STATUS, 32'h4);
    chk("irq", irq, 32'h1);
    wr(ADDR_IRQ_CLEAR, 32'h3f);
    rc("status", ADDR_IRQ_STATUS, 32'h0);
    chk("irq", irq, 32'h0);
    wr(ADDR_IRQ_ENABLE, 32'h0);
    fire(18'h0_0009); // Load refused by protection
    exc(VEC_DATA_FAULT);
    rc("cause", ADDR_CAUSE, 32'h2);
    chk("irq masked", irq, 32'h0);
    fire(18'h0_0031); // External word to write-through, access off
    exc(VEC_DATA_FAULT);
    rc("cause", ADDR_CAUSE, 32'h14);
    wr(ADDR_CTRL, 32'h2);
    fire(18'h0_0041); // Load to direct-store segment
    exc(VEC_DATA_FAULT);
    rc("cause", ADDR_CAUSE, 32'h4);
    fire(18'h0_0180);
    exc(VEC_FETCH_FAULT);
    fire(18'h0_0A80); // Supervisor fetch, key set, no read
    exc(VEC_FETCH_FAULT);
    fire(18'h0_0480); // User fetch, key set, no read
    exc(VEC_FETCH_FAULT);
    page_protect_bits <= 2'h2;
    fire(18'h0_0A80);
    none(6);
    al(18'h0_1000, 2'h2, 32'h0, 1'b1);
    al(18'h0_2000, 2'h1, 32'h0, 1'b1);
    al(18'h0_4000, 2'h1, 32'h0, 1'b0);
    al(18'h0_4000, 2'h1, 32'h4, 1'b1);
    al(18'h0_8000, 2'h0, 32'h4, 1'b1);
    al(18'h3_0000, 2'h0, 32'h0, 1'b1);
    al(18'h1_0020, 2'h0, 32'h0, 1'b1);
    sys.drive(7'h10);
    none(8);
    instr_busy <= 1'b1;
    wr(ADDR_CTRL, 32'h1);
    none(8);
    instr_complete <= 1'b1;
    exc(VEC_EXT_IRQ);
    sys.drive(7'h00);
    {instr_busy, instr_complete} <= 2'h0;
    repeat (8) @(posedge aclk);
    pin(7'h02, 6, VEC_SYS_RESET);
    pin(7'h01, 0, VEC_SYS_RESET);
    pin(7'h08, 6, VEC_MACH_CHECK);
    pin(7'h44, 0, VEC_MACH_CHECK);
    pin(7'h04, 0, VEC_RESERVED);
    pin(7'h20, 0, VEC_MACH_CHECK);
    pin(7'h0A, 0, VEC_SYS_RESET);
    sys.drive(7'h01);
    repeat (4) @(posedge aclk);
    fire(18'h0_0007);
    exc(VEC_SYS_RESET);
    sys.drive(7'h00);
    repeat (8) @(posedge aclk);
    final_report;
  end
endmodule
